// file: psis_regs.svh
// Functional notes
// - off-cause holds only latest power-off, machine clears
// - off-cause bit 13: alive regulator fault
// - off-cause bit 12: sequencing failure
// - off-cause bit 11: pin input caused off
// - off-cause bit 10: supply threshold forced off
// - off-cause bit 9: over-temperature caused off
// - off-cause bit 6: software wrote chip-on zero
// - off-cause bit 4: power button caused off
// - primary bits 15,14,13: state, thermal, pin-io
// - primary bits 12,11,8: button, watchdog, converter
// - primary bits 7,6,5: power-path, sink, clock
// - primary bits 4,2: memory, charger
// - primary bits 1,0: high current, undervoltage
// - secondary 15 latches on low-supply rise
// - secondary 14 latches on source-change rise
// - secondary 13 latches on usb-current rise
// - secondary 12 latches on both button edges
// - secondary 11 watchdog rise, 8 converter-ready rise
// - secondary 7: comparator four, direction selectable
// - secondary 6: comparator three, direction selectable
// - writing one clears secondary flag, zero keeps
`ifndef PSIS_REGS_SVH
`define PSIS_REGS_SVH
// register indices; byte address is four times the index
`define PSIS_IDX_OFF_CAUSE 16'h400F
`define PSIS_IDX_PRIMARY 16'h4010
`define PSIS_IDX_SEC_ONE 16'h4011
`define PSIS_IDX_SEC_MASK 16'h4019
`define PSIS_IDX_CMP_DIR 16'h4020
// off-cause bit positions
`define PSIS_OFF_REG_FAULT 13
`define PSIS_OFF_SEQ_FAIL 12
`define PSIS_OFF_PIN_IO 11
`define PSIS_OFF_SUPPLY 10
`define PSIS_OFF_OVERHEAT 9
`define PSIS_OFF_SW_CMD 6
`define PSIS_OFF_BUTTON 4
// primary bit positions
`define PSIS_PRI_STATE 15
`define PSIS_PRI_THERMAL 14
`define PSIS_PRI_PIN_IO 13
`define PSIS_PRI_BUTTON 12
`define PSIS_PRI_WDOG 11
`define PSIS_PRI_AUX 8
`define PSIS_PRI_PATH 7
`define PSIS_PRI_SINK 6
`define PSIS_PRI_RTC 5
`define PSIS_PRI_OTP 4
`define PSIS_PRI_CHARGER 2
`define PSIS_PRI_HIGH_CUR 1
`define PSIS_PRI_UNDERVOLT 0
// secondary bit positions
`define PSIS_SEC_LOW_SUPPLY 15
`define PSIS_SEC_SOURCE 14
`define PSIS_SEC_USB_CUR 13
`define PSIS_SEC_BUTTON 12
`define PSIS_SEC_WDOG 11
`define PSIS_SEC_AUX_READY 8
`define PSIS_SEC_CMP_FOUR 7
`define PSIS_SEC_CMP_THREE 6
// comparator direction field positions
`define PSIS_DIR_CMP_THREE 0
`define PSIS_DIR_CMP_FOUR 1
// valid bits, group masks, reset values
`define PSIS_OFF_VALID 16'h3E50
`define PSIS_PRI_VALID 16'hF9F7
`define PSIS_SEC_VALID 16'hF9C0
`define PSIS_DIR_VALID 16'h0003
`define PSIS_GRP_PATH 16'hE000
`define PSIS_GRP_BUTTON 16'h1000
`define PSIS_GRP_WDOG 16'h0800
`define PSIS_GRP_AUX 16'h01C0
`define PSIS_RST_STATUS 16'h0000
`define PSIS_RST_MASK 16'h0000
`define PSIS_RST_DIR 16'h0000
`endif

// file: psis_pkg.sv
package psis_pkg;
    typedef logic [15:0] psis_word_t;
    typedef logic [15:0] psis_index_t;
    // edge that sets a comparator flag
    typedef enum logic {
        PSIS_DIR_FALL,
        PSIS_DIR_RISE
    } psis_dir_t;
endpackage

// file: psis_top.sv
`timescale 1ns/1ps
`include "psis_regs.svh"
module psis_top
    import psis_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // main state machine, same clock
    input wire logic sm_off_strobe,
    input wire logic sm_cause_clear,
    input wire logic off_by_alive_regulator_fault,
    input wire logic off_by_sequence_failure,
    input wire logic off_by_pin_input,
    input wire logic off_by_supply_threshold,
    input wire logic off_by_overheat,
    input wire logic off_by_software_command,
    input wire logic off_by_button,
    // pending levels of groups kept elsewhere, same clock
    input wire logic power_state_pending,
    input wire logic thermal_pending,
    input wire logic pin_io_pending,
    input wire logic current_sink_pending,
    input wire logic rtc_pending,
    input wire logic otp_pending,
    input wire logic charger_pending,
    input wire logic high_current_pending,
    input wire logic undervoltage_pending,
    // event sources, asynchronous levels
    input wire logic low_supply_threshold,
    input wire logic power_source_change,
    input wire logic usb_current_event,
    input wire logic button_pin,
    input wire logic watchdog_timeout,
    input wire logic aux_converter_ready,
    input wire logic aux_comparator_four_gt,
    input wire logic aux_comparator_three_gt
);

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    psis_index_t idx_w;
    logic hit_w;
    logic acc_w;
    logic wr_w;

    assign idx_w = paddr[17:2];
    assign hit_w = (idx_w == `PSIS_IDX_OFF_CAUSE) || (idx_w == `PSIS_IDX_PRIMARY)
        || (idx_w == `PSIS_IDX_SEC_ONE) || (idx_w == `PSIS_IDX_SEC_MASK)
        || (idx_w == `PSIS_IDX_CMP_DIR);
    // transfer completes on the edge where pready is seen high
    assign acc_w = psel && penable && pready_q;
    assign wr_w = acc_w && pwrite && hit_w;

    ////////////////////////////////////////////////////////////////////////
    // event synchronisers

    psis_word_t raw_w;
    psis_word_t sync1_q;
    psis_word_t sync2_q;
    psis_word_t prev_q;

    always_comb begin
        raw_w = `PSIS_RST_STATUS;
        raw_w[`PSIS_SEC_LOW_SUPPLY] = low_supply_threshold;
        raw_w[`PSIS_SEC_SOURCE] = power_source_change;
        raw_w[`PSIS_SEC_USB_CUR] = usb_current_event;
        raw_w[`PSIS_SEC_BUTTON] = button_pin;
        raw_w[`PSIS_SEC_WDOG] = watchdog_timeout;
        raw_w[`PSIS_SEC_AUX_READY] = aux_converter_ready;
        raw_w[`PSIS_SEC_CMP_FOUR] = aux_comparator_four_gt;
        raw_w[`PSIS_SEC_CMP_THREE] = aux_comparator_three_gt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= `PSIS_RST_STATUS;
            sync2_q <= `PSIS_RST_STATUS;
            prev_q <= `PSIS_RST_STATUS;
        end else begin
            sync1_q <= raw_w;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers

    psis_word_t sec_mask_q;
    psis_word_t cmp_dir_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_mask_q <= `PSIS_RST_MASK;
        end else if (wr_w && idx_w == `PSIS_IDX_SEC_MASK) begin
            sec_mask_q <= pwdata[15:0] & `PSIS_SEC_VALID;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_dir_q <= `PSIS_RST_DIR;
        end else if (wr_w && idx_w == `PSIS_IDX_CMP_DIR) begin
            cmp_dir_q <= pwdata[15:0] & `PSIS_DIR_VALID;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge selection per secondary bit

    psis_word_t set_w;
    psis_dir_t dir_four_w;
    psis_dir_t dir_three_w;

    assign dir_four_w = psis_dir_t'(cmp_dir_q[`PSIS_DIR_CMP_FOUR]);
    assign dir_three_w = psis_dir_t'(cmp_dir_q[`PSIS_DIR_CMP_THREE]);

    localparam psis_word_t sec_valid_c = `PSIS_SEC_VALID;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_edge
            logic rise_w;
            logic fall_w;
            logic valid_w;
            assign rise_w = sync2_q[gi] && !prev_q[gi];
            assign fall_w = !sync2_q[gi] && prev_q[gi];
            assign valid_w = sec_valid_c[gi];
            if (gi == `PSIS_SEC_BUTTON) begin : g_both
                assign set_w[gi] = valid_w && (rise_w || fall_w);
            end else if (gi == `PSIS_SEC_CMP_FOUR) begin : g_cmp4
                assign set_w[gi] = valid_w
                    && ((dir_four_w == PSIS_DIR_RISE) ? rise_w : fall_w);
            end else if (gi == `PSIS_SEC_CMP_THREE) begin : g_cmp3
                assign set_w[gi] = valid_w
                    && ((dir_three_w == PSIS_DIR_RISE) ? rise_w : fall_w);
            end else begin : g_rise
                assign set_w[gi] = valid_w && rise_w;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // secondary flags, set wins over a clear in the same cycle

    psis_word_t sec_q;
    psis_word_t clr_w;

    assign clr_w = (wr_w && idx_w == `PSIS_IDX_SEC_ONE) ? pwdata[15:0] : `PSIS_RST_STATUS;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_q <= `PSIS_RST_STATUS;
        end else begin
            sec_q <= ((sec_q & ~clr_w) | set_w) & `PSIS_SEC_VALID;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // off-cause register

    psis_word_t off_q;
    psis_word_t off_d;

    always_comb begin
        off_d = `PSIS_RST_STATUS;
        off_d[`PSIS_OFF_REG_FAULT] = off_by_alive_regulator_fault;
        off_d[`PSIS_OFF_SEQ_FAIL] = off_by_sequence_failure;
        off_d[`PSIS_OFF_PIN_IO] = off_by_pin_input;
        off_d[`PSIS_OFF_SUPPLY] = off_by_supply_threshold;
        off_d[`PSIS_OFF_OVERHEAT] = off_by_overheat;
        off_d[`PSIS_OFF_SW_CMD] = off_by_software_command;
        off_d[`PSIS_OFF_BUTTON] = off_by_button;
    end

    // a new power-off replaces the old cause; the machine alone clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_q <= `PSIS_RST_STATUS;
        end else if (sm_off_strobe) begin
            off_q <= off_d;
        end else if (sm_cause_clear) begin
            off_q <= `PSIS_RST_STATUS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // primary summary word

    psis_word_t pri_q;
    psis_word_t pri_d;
    psis_word_t live_w;

    assign live_w = sec_q & ~sec_mask_q;

    always_comb begin
        pri_d = `PSIS_RST_STATUS;
        pri_d[`PSIS_PRI_STATE] = power_state_pending;
        pri_d[`PSIS_PRI_THERMAL] = thermal_pending;
        pri_d[`PSIS_PRI_PIN_IO] = pin_io_pending;
        pri_d[`PSIS_PRI_BUTTON] = |(live_w & `PSIS_GRP_BUTTON);
        pri_d[`PSIS_PRI_WDOG] = |(live_w & `PSIS_GRP_WDOG);
        pri_d[`PSIS_PRI_AUX] = |(live_w & `PSIS_GRP_AUX);
        pri_d[`PSIS_PRI_PATH] = |(live_w & `PSIS_GRP_PATH);
        pri_d[`PSIS_PRI_SINK] = current_sink_pending;
        pri_d[`PSIS_PRI_RTC] = rtc_pending;
        pri_d[`PSIS_PRI_OTP] = otp_pending;
        pri_d[`PSIS_PRI_CHARGER] = charger_pending;
        pri_d[`PSIS_PRI_HIGH_CUR] = high_current_pending;
        pri_d[`PSIS_PRI_UNDERVOLT] = undervoltage_pending;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pri_q <= `PSIS_RST_STATUS;
        end else begin
            pri_q <= pri_d & `PSIS_PRI_VALID;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus answer: one wait cycle, data and error registered

    psis_word_t rd_w;

    always_comb begin
        case (idx_w)
            `PSIS_IDX_OFF_CAUSE: rd_w = off_q;
            `PSIS_IDX_PRIMARY: rd_w = pri_q;
            `PSIS_IDX_SEC_ONE: rd_w = sec_q;
            `PSIS_IDX_SEC_MASK: rd_w = sec_mask_q;
            `PSIS_IDX_CMP_DIR: rd_w = cmp_dir_q;
            default: rd_w = `PSIS_RST_STATUS;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (psel && penable && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= !hit_w;
            prdata_q <= pwrite ? 32'h0000_0000 : {16'h0000, rd_w};
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_clear_write(int b);
        wr_w && idx_w == `PSIS_IDX_SEC_ONE && pwdata[b] && !set_w[b];
    endsequence

    chk_off_latest_cause: assert property (
        sm_off_strobe |=> off_q == $past(off_d))
        else $error("off-cause did not take the latest cause");

    chk_off_machine_clear: assert property (
        !sm_off_strobe && sm_cause_clear |=> off_q == `PSIS_RST_STATUS)
        else $error("off-cause not cleared by the machine");

    chk_off_bits_place: assert property (
        sm_off_strobe |=> off_q[13] == $past(off_by_alive_regulator_fault)
            && off_q[12] == $past(off_by_sequence_failure)
            && off_q[11] == $past(off_by_pin_input)
            && off_q[10] == $past(off_by_supply_threshold)
            && off_q[9] == $past(off_by_overheat)
            && off_q[6] == $past(off_by_software_command)
            && off_q[4] == $past(off_by_button))
        else $error("off-cause bit misplaced");

    chk_off_held: assert property (
        !sm_off_strobe && !sm_cause_clear |=> $stable(off_q))
        else $error("off-cause changed without the machine");

    chk_pri_ext_place: assert property (
        1'b1 |=> pri_q[15] == $past(power_state_pending)
            && pri_q[14] == $past(thermal_pending) && pri_q[13] == $past(pin_io_pending)
            && pri_q[6] == $past(current_sink_pending) && pri_q[5] == $past(rtc_pending)
            && pri_q[4] == $past(otp_pending) && pri_q[2] == $past(charger_pending)
            && pri_q[1] == $past(high_current_pending)
            && pri_q[0] == $past(undervoltage_pending))
        else $error("primary word bit misplaced");

    chk_pri_group_or: assert property (
        1'b1 |=> pri_q[7] == |($past(sec_q[15:13]) & ~$past(sec_mask_q[15:13]))
            && pri_q[8] == |($past(sec_q[8:6]) & ~$past(sec_mask_q[8:6])))
        else $error("primary group is not the OR of unmasked flags");

    chk_button_both_edges: assert property (
        sync2_q[12] != prev_q[12] |=> sec_q[12])
        else $error("button edge not latched");

    chk_rise_latch: assert property (
        sync2_q[15] && !prev_q[15] |=> sec_q[15])
        else $error("low-supply rise not latched");

    chk_wdog_fall_ignored: assert property (
        !sync2_q[11] && prev_q[11] && !sec_q[11] |=> !sec_q[11])
        else $error("watchdog fall latched");

    chk_cmp_dir_sel: assert property (
        cmp_dir_q[1] == 1'b0 && !sync2_q[7] && prev_q[7] |=> sec_q[7])
        else $error("comparator four falling trigger missed");

    chk_clear_one: assert property (
        s_clear_write(14) |=> !sec_q[14])
        else $error("write of one did not clear the flag");

    chk_set_beats_clear: assert property (
        wr_w && idx_w == `PSIS_IDX_SEC_ONE && set_w[13] |=> sec_q[13])
        else $error("event lost against a clear");

    chk_reserved_zero: assert property (
        (sec_q & ~`PSIS_SEC_VALID) == 16'h0000 && (pri_q & ~`PSIS_PRI_VALID) == 16'h0000)
        else $error("reserved bit set");

    chk_ready_one_wait: assert property (
        psel && !penable ##1 psel && penable |=> pready_q ##1 !pready_q)
        else $error("bus answer not after one wait cycle");

    sequence s_rise(int b);
        sync2_q[b] && !prev_q[b];
    endsequence

    chk_source_rise: assert property (
        s_rise(14) |=> sec_q[14])
        else $error("source-change rise not latched");

    chk_usb_rise: assert property (
        s_rise(13) |=> sec_q[13])
        else $error("usb-current rise not latched");

    chk_converter_ready_rise: assert property (
        s_rise(8) |=> sec_q[8])
        else $error("converter-ready rise not latched");

    chk_cmp_three_rise: assert property (
        cmp_dir_q[0] ##0 s_rise(6) |=> sec_q[6])
        else $error("comparator three rising trigger missed");

    chk_cmp_three_skip: assert property (
        !cmp_dir_q[0] && !sec_q[6] ##0 s_rise(6) |=> !sec_q[6])
        else $error("comparator three rise latched while falling selected");

    chk_pri_button_wdog: assert property (
        1'b1 |=> pri_q[12] == $past(sec_q[12] && !sec_mask_q[12])
            && pri_q[11] == $past(sec_q[11] && !sec_mask_q[11]))
        else $error("button or watchdog summary wrong");

    chk_zero_write_keeps: assert property (
        wr_w && idx_w == `PSIS_IDX_SEC_ONE
            |=> ($past(sec_q) & ~$past(pwdata[15:0]) & ~sec_q) == 16'h0000)
        else $error("flag lost on a write of zero");

    chk_unmapped_error: assert property (
        psel && penable && !pready_q && !hit_w |=> pready_q && pslverr_q)
        else $error("unmapped index answered without error");

endmodule

// file: test_power_event_source_and_irq_status.sv
`timescale 1ns/1ps
`include "psis_regs.svh"
module test_power_event_source_and_irq_status
    import psis_pkg::*;
;
    localparam logic [17:0] A_OFF = 18'h1_003C;
    localparam logic [17:0] A_PRI = 18'h1_0040;
    localparam logic [17:0] A_SEC = 18'h1_0044;
    localparam logic [17:0] A_MSK = 18'h1_0064;
    localparam logic [17:0] A_DIR = 18'h1_0080;
    localparam logic [17:0] A_BAD = 18'h1_0048;
    localparam int off_pos[7] = '{13, 12, 11, 10, 9, 6, 4};
    localparam int pend_pos[9] = '{15, 14, 13, 6, 5, 4, 2, 1, 0};
    localparam int sec_pos[8] = '{15, 14, 13, 12, 11, 8, 7, 6};
    localparam int grp_pos[8] = '{7, 7, 7, 12, 11, 8, 8, 8};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic sm_off_strobe, sm_cause_clear, err;
    logic [6:0] offb;
    logic [8:0] pend;
    logic [7:0] ev;
    int mismatches = 0;
    int cmp_count = 0;

    ////////////////////////////////////////////////////////////////////////////
    psis_top u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sm_off_strobe(sm_off_strobe), .sm_cause_clear(sm_cause_clear),
        .off_by_alive_regulator_fault(offb[0]), .off_by_sequence_failure(offb[1]),
        .off_by_pin_input(offb[2]), .off_by_supply_threshold(offb[3]),
        .off_by_overheat(offb[4]), .off_by_software_command(offb[5]), .off_by_button(offb[6]),
        .power_state_pending(pend[0]), .thermal_pending(pend[1]), .pin_io_pending(pend[2]),
        .current_sink_pending(pend[3]), .rtc_pending(pend[4]), .otp_pending(pend[5]),
        .charger_pending(pend[6]), .high_current_pending(pend[7]),
        .undervoltage_pending(pend[8]),
        .low_supply_threshold(ev[0]), .power_source_change(ev[1]), .usb_current_event(ev[2]),
        .button_pin(ev[3]), .watchdog_timeout(ev[4]), .aux_converter_ready(ev[5]),
        .aux_comparator_four_gt(ev[6]), .aux_comparator_three_gt(ev[7])
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic print_verdict();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic xfer(input logic wr, input logic [17:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic strobe(input logic s, input logic c);
        @(posedge pclk);
        sm_off_strobe <= s;
        sm_cause_clear <= c;
        @(posedge pclk);
        sm_off_strobe <= 1'b0;
        sm_cause_clear <= 1'b0;
    endtask

    initial begin
        #(40 * 20000);
        mismatches++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, sm_off_strobe, sm_cause_clear} = '0;
        paddr = '0;
        pwdata = '0;
        offb = '0;
        pend = '0;
        ev = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, read-only places and an unmapped index
        rd_chk(A_OFF, 32'h0000_0000);
        rd_chk(A_PRI, 32'h0000_0000);
        rd_chk(A_SEC, 32'h0000_0000);
        xfer(1'b1, A_OFF, 32'h0000_FFFF);
        rd_chk(A_OFF, 32'h0000_0000);
        xfer(1'b0, A_BAD, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        // off-cause: each cause alone, then replacement and clearing
        for (int i = 0; i < 7; i++) begin
            offb <= 7'(1 << i);
            strobe(1'b1, 1'b0);
            rd_chk(A_OFF, 32'(1 << off_pos[i]));
        end
        offb <= 7'h03;
        strobe(1'b1, 1'b0);
        offb <= 7'h20;
        strobe(1'b1, 1'b0);
        rd_chk(A_OFF, 32'(1 << `PSIS_OFF_SW_CMD));
        offb <= 7'h40;
        strobe(1'b1, 1'b1);
        rd_chk(A_OFF, 32'(1 << `PSIS_OFF_BUTTON));
        strobe(1'b0, 1'b1);
        rd_chk(A_OFF, 32'h0000_0000);
        // pending levels of the other groups
        for (int i = 0; i < 9; i++) begin
            pend <= 9'(1 << i);
            cyc(3);
            rd_chk(A_PRI, 32'(1 << pend_pos[i]));
        end
        pend <= '0;
        // each event pulsed high then low, a zero write keeps it, a one clears it
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            ev[i] <= 1'b1;
            cyc(3);
            ev[i] <= 1'b0;
            cyc(6);
            rd_chk(A_SEC, 32'(1 << sec_pos[i]));
            rd_chk(A_PRI, 32'(1 << grp_pos[i]));
            xfer(1'b1, A_SEC, 32'hFFFF_0000 | ~(32'(1 << sec_pos[i])) & 32'h0000_FFFF);
            rd_chk(A_SEC, 32'(1 << sec_pos[i]));
            xfer(1'b1, A_SEC, 32'(1 << sec_pos[i]));
            rd_chk(A_SEC, 32'h0000_0000);
            rd_chk(A_PRI, 32'h0000_0000);
        end
        // button release alone sets the flag again
        ev[3] <= 1'b1;
        cyc(8);
        xfer(1'b1, A_SEC, 32'h0000_F9C0);
        ev[3] <= 1'b0;
        cyc(8);
        rd_chk(A_SEC, 32'(1 << `PSIS_SEC_BUTTON));
        xfer(1'b1, A_SEC, 32'h0000_FFFF);
        // comparators: three ignores a rise by default, four and three latch a rise once rising is selected
        ev[7] <= 1'b1;
        cyc(8);
        rd_chk(A_SEC, 32'h0000_0000);
        ev[7] <= 1'b0;
        cyc(8);
        xfer(1'b1, A_SEC, 32'h0000_FFFF);
        xfer(1'b1, A_DIR, 32'h0000_0003);
        rd_chk(A_DIR, 32'h0000_0003);
        ev[6] <= 1'b1;
        cyc(8);
        rd_chk(A_SEC, 32'(1 << `PSIS_SEC_CMP_FOUR));
        ev[6] <= 1'b0;
        cyc(8);
        rd_chk(A_SEC, 32'(1 << `PSIS_SEC_CMP_FOUR));
        xfer(1'b1, A_SEC, 32'h0000_0080);
        ev[7] <= 1'b1;
        cyc(8);
        rd_chk(A_SEC, 32'(1 << `PSIS_SEC_CMP_THREE));
        xfer(1'b1, A_SEC, 32'h0000_0040);
        ev[7] <= 1'b0;
        // a masked flag latches but stays out of the summary
        xfer(1'b1, A_MSK, 32'h0000_2000);
        rd_chk(A_MSK, 32'h0000_2000);
        ev[2] <= 1'b1;
        cyc(8);
        rd_chk(A_SEC, 32'(1 << `PSIS_SEC_USB_CUR));
        rd_chk(A_PRI, 32'h0000_0000);
        xfer(1'b1, A_MSK, 32'h0000_0000);
        cyc(2);
        rd_chk(A_PRI, 32'(1 << `PSIS_PRI_PATH));
        xfer(1'b1, A_SEC, 32'h0000_2000);
        rd_chk(A_PRI, 32'h0000_0000);
        // every cause at once, then a reset in mid-run clears all again
        ev <= '0;
        offb <= 7'h7F;
        strobe(1'b1, 1'b0);
        rd_chk(A_OFF, 32'h0000_3E50);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(A_OFF, 32'h0000_0000);
        rd_chk(A_DIR, 32'h0000_0000);
        rd_chk(A_PRI, 32'h0000_0000);
        print_verdict();
    end
endmodule
